/* core/rpf_cfg.svh */
// Purpose: named constants of the reset pin filter and watchdog reset sequencer
// Assumes: core clock of 100 MHz
// Notes:   definitions only
`ifndef RPF_CFG_SVH
`define RPF_CFG_SVH

`define RPF_CLK_PERIOD_NS     10
`define RPF_SAMPLE_PERIOD_NS  100
`define RPF_ANALOG_DELAY_NS   200
`define RPF_N_LONG            20
`define RPF_N_SHORT           10
`define RPF_WD1_HOLD_CLKS     12
`define RPF_SETTLE_UNIT       256
`define RPF_OSC_SETTLE_SELECT_DEFAULT      3'h4

`define RPF_CTRL_ADDR         32'hfffff860
`define RPF_FLAGS_ADDR        32'hfffff888
`define RPF_CTRL_RESET        8'h00
`define RPF_FLAGS_RESET       8'h00
`define RPF_BIT_FILTER_SEL    0
`define RPF_BIT_SAMPLE_SEL    1
`define RPF_BIT_WD2_FLAG      4
`define RPF_BIT_WD1_FLAG      7

`endif

/* core/rpf_pkg.sv */
// Purpose: types of the reset pin filter and watchdog reset sequencer
// Assumes: nothing
// Notes:   constants live in rpf_cfg.svh
package rpf_pkg;
   typedef logic [7:0]  rpf_byte_t;
   typedef logic [31:0] rpf_addr_t;
   typedef enum logic [4:0] {
      RPF_ST_RUN    = 5'b00001,
      RPF_ST_PIN    = 5'b00010,
      RPF_ST_WD1    = 5'b00100,
      RPF_ST_WD2    = 5'b01000,
      RPF_ST_SETTLE = 5'b10000
   } rpf_state_t;
endpackage

/* core/rpf_reset_ctrl.sv */
// Purpose: reset pin noise filter and watchdog 1/2 reset sequencer
// Assumes: watchdog requests, stop and clock-source signals come from core-clock logic
// Notes:   reset pin and oscillator-running level are pins and pass two flip-flops
// Summary of operation
// - filter_select picks digital plus analog, else analog
// - main clock sampling, 20 or 10 samples
// - control byte: bit1 sample count, bit0 filter
// - stopped sampling clock forces analog-only filtering
// - control register accepts only first write
// - all samples low, then analog delay, resets
// - internal reset clears the control register
// - stop mode forces analog until settle ends
// - subclock operation forces analog-only filtering
// - short pulses rejected, (N+1)-period pulses reset
// - enabled watchdog 1 overflow resets system
// - watchdog 1 reset held 12 clocks
// - watchdog 1 reset skips oscillator settle wait
// - clocks keep running, reinitialised to divide-by-8
// - reset port drives low, other ports float
// - ram content kept across watchdog 1 reset
// - watchdog 2 reset lasts the analog delay
// - watchdog 2 release waits default settle time
// - watchdog 2 reset behaves like pin reset
// - watchdog resets set own flag, pin clears
// - filtered low pin holds reset until high
`timescale 1ns/1ps
`default_nettype none
`include "rpf_cfg.svh"
module rpf_reset_ctrl #(
   parameter int OSC_SETTLE_UNIT = `RPF_SETTLE_UNIT,
   parameter int N_LONG          = `RPF_N_LONG,
   parameter int N_SHORT         = `RPF_N_SHORT
) (
   input  wire logic              CORE_CLK,
   input  wire logic              RST_N,
   input  wire logic              RESET_PIN_N,
   input  wire logic              MAIN_OSC_RUN,
   input  wire logic              STOP_ENTRY,
   input  wire logic              STOP_RELEASE,
   input  wire logic [2:0]        OSC_SETTLE_SELECT,
   input  wire logic              CLOCK_SOURCE_SELECT,
   input  wire logic              WDOG1_RESET_ENABLE,
   input  wire logic              WDOG1_RESET_REQUEST,
   input  wire logic              WDOG2_RESET_ENABLE,
   input  wire logic              WDOG2_RESET_REQUEST,
   input  wire rpf_pkg::rpf_addr_t REG_ADDR,
   input  wire rpf_pkg::rpf_byte_t REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output rpf_pkg::rpf_byte_t     REG_RDATA,
   output logic                   SYS_RESET_N,
   output logic                   CPU_RUN,
   output logic                   MAIN_OSC_STOP,
   output logic                   CLK_DIV8_INIT,
   output logic                   RESET_PORT_OUT,
   output logic                   RESET_PORT_OE_N,
   output logic                   OTHER_PORTS_HIZ,
   output logic                   DIGITAL_FILTER_ON
);
   import rpf_pkg::*;

   localparam int SAMPLE_CLKS = (`RPF_SAMPLE_PERIOD_NS + `RPF_CLK_PERIOD_NS - 1) / `RPF_CLK_PERIOD_NS;
   localparam int ANA_CLKS_R  = (`RPF_ANALOG_DELAY_NS + `RPF_CLK_PERIOD_NS - 1) / `RPF_CLK_PERIOD_NS;
   localparam int ANA_CLKS    = (ANA_CLKS_R < 1) ? 1 : ANA_CLKS_R;
   localparam int SW          = 16;
   localparam int DW          = $clog2(SAMPLE_CLKS + 1);
   localparam int AW          = $clog2(ANA_CLKS + 1);

   function automatic logic [SW-1:0] settle_clks(input logic [2:0] sel);
      settle_clks = SW'(OSC_SETTLE_UNIT << sel);
   endfunction

   // pin synchronisers
   logic pin_n_m;
   logic pin_n_s;
   logic osc_m;
   logic osc_s;
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         pin_n_m <= 1'b1;
         pin_n_s <= 1'b1;
         osc_m   <= 1'b0;
         osc_s   <= 1'b0;
      end else begin
         pin_n_m <= RESET_PIN_N;
         pin_n_s <= pin_n_m;
         osc_m   <= MAIN_OSC_RUN;
         osc_s   <= osc_m;
      end
   end
   wire logic pin_low = !pin_n_s;

   // analog-only forcing: stop mode and subclock operation
   logic            stop_force;
   logic            next_stop_force;
   logic            stop_settling;
   logic            next_stop_settling;
   logic [SW-1:0]   stop_cnt;
   logic [SW-1:0]   next_stop_cnt;
   logic            subclk_force;
   logic            next_subclk_force;
   logic            cls_q;

   always_comb begin
      next_stop_force    = stop_force;
      next_stop_settling = stop_settling;
      next_stop_cnt      = stop_cnt;
      if (STOP_ENTRY) begin
         next_stop_force    = 1'b1;
         next_stop_settling = 1'b0;
      end else if (stop_force && STOP_RELEASE && !stop_settling) begin
         next_stop_settling = 1'b1;
         next_stop_cnt      = settle_clks(OSC_SETTLE_SELECT) - 1'b1;
      end else if (stop_settling) begin
         if (stop_cnt == '0) begin
            next_stop_force    = 1'b0;
            next_stop_settling = 1'b0;
         end else begin
            next_stop_cnt = stop_cnt - 1'b1;
         end
      end
      next_subclk_force = subclk_force;
      if (!cls_q && CLOCK_SOURCE_SELECT) begin
         next_subclk_force = 1'b1;
      end else if (cls_q && !CLOCK_SOURCE_SELECT) begin
         next_subclk_force = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         stop_force    <= 1'b0;
         stop_settling <= 1'b0;
         stop_cnt      <= '0;
         subclk_force  <= 1'b0;
         cls_q         <= 1'b0;
      end else begin
         stop_force    <= next_stop_force;
         stop_settling <= next_stop_settling;
         stop_cnt      <= next_stop_cnt;
         subclk_force  <= next_subclk_force;
         cls_q         <= CLOCK_SOURCE_SELECT;
      end
   end

   // registers and reset sequencer
   rpf_byte_t  ctrl;
   rpf_byte_t  next_ctrl;
   logic       locked;
   logic       next_locked;
   rpf_byte_t  flags;
   rpf_byte_t  next_flags;
   rpf_byte_t  next_rdata;
   rpf_state_t st;
   rpf_state_t next_st;
   logic [SW-1:0] seq_cnt;
   logic [SW-1:0] next_seq_cnt;

   wire logic in_reset   = (st == RPF_ST_PIN) || (st == RPF_ST_WD1) || (st == RPF_ST_WD2);
   wire logic dig_active = ctrl[`RPF_BIT_FILTER_SEL] && osc_s && !stop_force && !subclk_force;

   // sampling tick from the main oscillator; halts while it is stopped
   logic [DW-1:0] div_cnt;
   logic [DW-1:0] next_div_cnt;
   logic          sample_tick;
   logic          next_sample_tick;
   always_comb begin
      next_div_cnt     = div_cnt;
      next_sample_tick = 1'b0;
      if (osc_s) begin
         if (div_cnt == '0) begin
            next_div_cnt     = DW'(SAMPLE_CLKS - 1);
            next_sample_tick = 1'b1;
         end else begin
            next_div_cnt = div_cnt - 1'b1;
         end
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         div_cnt     <= '0;
         sample_tick <= 1'b0;
      end else begin
         div_cnt     <= next_div_cnt;
         sample_tick <= next_sample_tick;
      end
   end

   logic dig_detect;
   rpf_sample_filter #(
      .N_LONG  (N_LONG),
      .N_SHORT (N_SHORT)
   ) u_filter (
      .clk         (CORE_CLK),
      .rst_n       (RST_N),
      .sample_tick (sample_tick),
      .pin_low     (pin_low),
      .short_sel   (ctrl[`RPF_BIT_SAMPLE_SEL]),
      .enable      (dig_active),
      .detect      (dig_detect)
   );
   // analog delay after the digital stage, or alone
   logic [AW-1:0] ana_cnt;
   logic [AW-1:0] next_ana_cnt;
   wire logic filt_low = dig_active ? dig_detect : pin_low;
   wire logic pin_rst  = (ana_cnt == AW'(ANA_CLKS));
   always_comb begin
      next_ana_cnt = ana_cnt;
      if (!filt_low) begin
         next_ana_cnt = '0;
      end else if (ana_cnt != AW'(ANA_CLKS)) begin
         next_ana_cnt = ana_cnt + 1'b1;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ana_cnt <= '0;
      end else begin
         ana_cnt <= next_ana_cnt;
      end
   end

   wire logic ctrl_hit  = (REG_ADDR == `RPF_CTRL_ADDR);
   wire logic flags_hit = (REG_ADDR == `RPF_FLAGS_ADDR);
   wire logic wd1_go    = WDOG1_RESET_ENABLE && WDOG1_RESET_REQUEST;
   wire logic wd2_go    = WDOG2_RESET_ENABLE && WDOG2_RESET_REQUEST;
   always_comb begin
      next_st      = st;
      next_seq_cnt = seq_cnt;
      if (pin_rst) begin
         next_st = RPF_ST_PIN;
      end else begin
         unique case (st)
            RPF_ST_RUN: begin
               if (wd2_go) begin
                  next_st      = RPF_ST_WD2;
                  next_seq_cnt = SW'(ANA_CLKS - 1);
               end else if (wd1_go) begin
                  next_st      = RPF_ST_WD1;
                  next_seq_cnt = SW'(`RPF_WD1_HOLD_CLKS - 1);
               end
            end
            RPF_ST_PIN: begin
               next_st      = RPF_ST_SETTLE;
               next_seq_cnt = settle_clks(`RPF_OSC_SETTLE_SELECT_DEFAULT) - 1'b1;
            end
            RPF_ST_WD1: begin
               if (seq_cnt == '0) begin
                  next_st = RPF_ST_RUN;
               end else begin
                  next_seq_cnt = seq_cnt - 1'b1;
               end
            end
            RPF_ST_WD2: begin
               if (seq_cnt == '0) begin
                  next_st      = RPF_ST_SETTLE;
                  next_seq_cnt = settle_clks(`RPF_OSC_SETTLE_SELECT_DEFAULT) - 1'b1;
               end else begin
                  next_seq_cnt = seq_cnt - 1'b1;
               end
            end
            RPF_ST_SETTLE: begin
               if (seq_cnt == '0) begin
                  next_st = RPF_ST_RUN;
               end else begin
                  next_seq_cnt = seq_cnt - 1'b1;
               end
            end
         endcase
      end

      next_ctrl   = ctrl;
      next_locked = locked;
      if (in_reset) begin
         next_ctrl   = `RPF_CTRL_RESET;
         next_locked = 1'b0;
      end else if (REG_WR && ctrl_hit && !locked) begin
         next_ctrl   = {6'h00, REG_WDATA[`RPF_BIT_SAMPLE_SEL], REG_WDATA[`RPF_BIT_FILTER_SEL]};
         next_locked = 1'b1;
      end

      // software writes zeros to clear; a watchdog set in the same cycle wins
      next_flags = flags;
      if (REG_WR && flags_hit) begin
         next_flags = flags & REG_WDATA;
      end
      if (next_st == RPF_ST_PIN && st != RPF_ST_PIN) begin
         next_flags = `RPF_FLAGS_RESET;
      end
      if (next_st == RPF_ST_WD1 && st != RPF_ST_WD1) begin
         next_flags[`RPF_BIT_WD1_FLAG] = 1'b1;
      end
      if (next_st == RPF_ST_WD2 && st != RPF_ST_WD2) begin
         next_flags[`RPF_BIT_WD2_FLAG] = 1'b1;
      end

      next_rdata = 8'h00;
      if (REG_RD && ctrl_hit) begin
         next_rdata = ctrl;
      end else if (REG_RD && flags_hit) begin
         next_rdata = flags;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         st                <= RPF_ST_RUN;
         seq_cnt           <= '0;
         ctrl              <= `RPF_CTRL_RESET;
         locked            <= 1'b0;
         flags             <= `RPF_FLAGS_RESET;
         REG_RDATA         <= 8'h00;
         SYS_RESET_N       <= 1'b1;
         CPU_RUN           <= 1'b1;
         MAIN_OSC_STOP     <= 1'b0;
         CLK_DIV8_INIT     <= 1'b0;
         RESET_PORT_OUT    <= 1'b0;
         RESET_PORT_OE_N   <= 1'b1;
         OTHER_PORTS_HIZ   <= 1'b0;
         DIGITAL_FILTER_ON <= 1'b0;
      end else begin
         st                <= next_st;
         seq_cnt           <= next_seq_cnt;
         ctrl              <= next_ctrl;
         locked            <= next_locked;
         flags             <= next_flags;
         REG_RDATA         <= next_rdata;
         // state outputs decode the next state so they line up with st; DIGITAL_FILTER_ON lags dig_active by one cycle
         SYS_RESET_N       <= !(next_st inside {RPF_ST_PIN, RPF_ST_WD1, RPF_ST_WD2});
         CPU_RUN           <= (next_st == RPF_ST_RUN);
         // watchdog 1 keeps the oscillator alive, so no settle wait follows
         MAIN_OSC_STOP     <= (next_st inside {RPF_ST_PIN, RPF_ST_WD2});
         CLK_DIV8_INIT     <= (next_st inside {RPF_ST_PIN, RPF_ST_WD1, RPF_ST_WD2});
         RESET_PORT_OUT    <= 1'b0;
         RESET_PORT_OE_N   <= !(next_st inside {RPF_ST_PIN, RPF_ST_WD1, RPF_ST_WD2});
         OTHER_PORTS_HIZ   <= (next_st inside {RPF_ST_PIN, RPF_ST_WD1, RPF_ST_WD2});
         DIGITAL_FILTER_ON <= ctrl[`RPF_BIT_FILTER_SEL] && osc_s && !stop_force && !subclk_force;
      end
   end
   // ram holds no state here; the sequencer never issues a ram clear
   wd1_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N || pin_rst)
      (st == RPF_ST_WD1 && $past(st) != RPF_ST_WD1) |->
         (st == RPF_ST_WD1)[*8] ##1 (st == RPF_ST_WD1)[*4] ##1 (st == RPF_ST_RUN))
      else $error("watchdog 1 reset not held exactly twelve clocks");
   wd1_no_settle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (st == RPF_ST_WD1 && $past(st) == RPF_ST_WD1 && seq_cnt == '0 && !pin_rst) |=> (CPU_RUN && !MAIN_OSC_STOP))
      else $error("cpu not restarted right after watchdog 1 reset");
   wd2_settle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (st == RPF_ST_SETTLE && $past(st) == RPF_ST_WD2) |-> (seq_cnt == settle_clks(`RPF_OSC_SETTLE_SELECT_DEFAULT) - 1'b1 && !CPU_RUN))
      else $error("watchdog 2 release without default settle time");
   write_once_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($past(locked) && !$past(in_reset)) |-> (ctrl == $past(ctrl)))
      else $error("locked control register changed");
   ctrl_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $past(in_reset) |-> (ctrl == `RPF_CTRL_RESET && !locked))
      else $error("control register not cleared by internal reset");
   force_analog_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (stop_force || subclk_force || !osc_s) |-> !dig_active)
      else $error("digital filter active while it must be bypassed");
   wd1_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (st == RPF_ST_WD1 && $past(st) != RPF_ST_WD1) |-> flags[`RPF_BIT_WD1_FLAG])
      else $error("watchdog 1 flag not set");
   port_low_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !SYS_RESET_N |-> (!RESET_PORT_OE_N && !RESET_PORT_OUT && OTHER_PORTS_HIZ && CLK_DIV8_INIT))
      else $error("port states wrong during reset");
   ctrl_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $past(REG_RD && ctrl_hit) |-> (REG_RDATA == $past(ctrl) && REG_RDATA[7:2] == 6'h00))
      else $error("control register read back wrong");
endmodule
`default_nettype wire

/* core/rpf_sample_filter.sv */
// Purpose: counts consecutive low samples of the reset pin
// Assumes: sample_tick is one cycle per sampling period, pin_low already synchronised
// Notes:   detect stays high until a high sample or the filter is disabled
`timescale 1ns/1ps
`default_nettype none
`include "rpf_cfg.svh"
module rpf_sample_filter #(
   parameter int N_LONG  = `RPF_N_LONG,
   parameter int N_SHORT = `RPF_N_SHORT
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sample_tick,
   input  wire logic pin_low,
   input  wire logic short_sel,
   input  wire logic enable,
   output logic      detect
);
   import rpf_pkg::*;
   localparam int CW = $clog2(N_LONG + 1);

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic [CW-1:0] target;
   logic          next_detect;

   always_comb begin
      target      = short_sel ? CW'(N_SHORT) : CW'(N_LONG);
      next_cnt    = cnt;
      next_detect = detect;
      if (!enable) begin
         next_cnt    = '0;
         next_detect = 1'b0;
      end else if (sample_tick) begin
         if (!pin_low) begin
            // one high sample restarts the window
            next_cnt    = '0;
            next_detect = 1'b0;
         end else if (cnt < target) begin
            next_cnt    = cnt + 1'b1;
            next_detect = ((cnt + 1'b1) == target);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt    <= '0;
         detect <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         detect <= next_detect;
      end
   end

   high_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
      (enable && sample_tick && !pin_low) |=> (cnt == '0 && !detect))
      else $error("high sample did not restart the filter");

   detect_count_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(detect) |-> ($past(cnt) == $past(target) - 1'b1 && $past(pin_low) && $past(sample_tick)))
      else $error("detect raised before the full window was low");
endmodule
`default_nettype wire

/* tb/reset_pin_filter_and_wdt_reset_tb.sv */
// Purpose: self-checking bench of the reset pin filter and watchdog reset sequencer
// Assumes: settle unit shrunk to 4, so a default settle wait is 64 cycles
// Notes:   outputs are sampled 1 ns after the rising edge, once registers have settled
`timescale 1ns/1ps
`default_nettype none
`include "rpf_cfg.svh"
module reset_pin_filter_and_wdt_reset_tb;
   import rpf_pkg::*;
   localparam int UNIT   = 4;
   localparam int SETTLE = UNIT << `RPF_OSC_SETTLE_SELECT_DEFAULT;
   localparam rpf_addr_t CTRL  = `RPF_CTRL_ADDR;
   localparam rpf_addr_t FLAGS = `RPF_FLAGS_ADDR;

   logic CORE_CLK = 1'b0, RST_N = 1'b0, MAIN_OSC_RUN = 1'b1, STOP_ENTRY = 1'b0, STOP_RELEASE = 1'b0;
   logic [2:0] OSC_SETTLE_SELECT = 3'h0;
   logic CLOCK_SOURCE_SELECT = 1'b0, WDOG1_RESET_ENABLE = 1'b0, WDOG1_RESET_REQUEST = 1'b0;
   logic WDOG2_RESET_ENABLE = 1'b0, WDOG2_RESET_REQUEST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
   rpf_addr_t REG_ADDR = 32'h0;
   rpf_byte_t REG_WDATA = 8'h00, REG_RDATA;
   logic RESET_PIN_N, SYS_RESET_N, CPU_RUN, MAIN_OSC_STOP, CLK_DIV8_INIT;
   logic RESET_PORT_OUT, RESET_PORT_OE_N, OTHER_PORTS_HIZ, DIGITAL_FILTER_ON;
   int miscompares = 0, check_count = 0, falls = 0, lo, se, f0;
   logic osc_stop_seen, out_ok;

   rpf_pin_source DRV (.clk(CORE_CLK), .pin_n(RESET_PIN_N));

   rpf_reset_ctrl #(.OSC_SETTLE_UNIT(UNIT), .N_LONG(`RPF_N_LONG), .N_SHORT(`RPF_N_SHORT)) DUT (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .RESET_PIN_N(RESET_PIN_N), .MAIN_OSC_RUN(MAIN_OSC_RUN),
      .STOP_ENTRY(STOP_ENTRY), .STOP_RELEASE(STOP_RELEASE), .OSC_SETTLE_SELECT(OSC_SETTLE_SELECT),
      .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .WDOG1_RESET_ENABLE(WDOG1_RESET_ENABLE),
      .WDOG1_RESET_REQUEST(WDOG1_RESET_REQUEST), .WDOG2_RESET_ENABLE(WDOG2_RESET_ENABLE),
      .WDOG2_RESET_REQUEST(WDOG2_RESET_REQUEST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SYS_RESET_N(SYS_RESET_N),
      .CPU_RUN(CPU_RUN), .MAIN_OSC_STOP(MAIN_OSC_STOP), .CLK_DIV8_INIT(CLK_DIV8_INIT),
      .RESET_PORT_OUT(RESET_PORT_OUT), .RESET_PORT_OE_N(RESET_PORT_OE_N),
      .OTHER_PORTS_HIZ(OTHER_PORTS_HIZ), .DIGITAL_FILTER_ON(DIGITAL_FILTER_ON));

   initial begin
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   always @(negedge SYS_RESET_N) falls++;

   task automatic test_done();
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step();
      @(posedge CORE_CLK);
      #1;
   endtask

   task automatic reg_write(input rpf_addr_t a, input rpf_byte_t d);
      @(posedge CORE_CLK);
      REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic expect_reg(input rpf_addr_t a, input rpf_byte_t exp);
      @(posedge CORE_CLK);
      REG_ADDR <= a; REG_RD <= 1'b1;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      #1 check(REG_RDATA, exp);
   endtask

   // waits for a reset, counts its low cycles, then the cycles of held-back cpu
   task automatic measure(input int hold, output int low_n, output int settle_n);
      int i;
      low_n = 0; settle_n = 0; osc_stop_seen = 1'b0; out_ok = 1'b1;
      for (i = 0; i < 600 && SYS_RESET_N !== 1'b0; i++) step();
      while (SYS_RESET_N === 1'b0 && low_n < 3000) begin
         if (MAIN_OSC_STOP === 1'b1) osc_stop_seen = 1'b1;
         if (!(CLK_DIV8_INIT === 1'b1 && RESET_PORT_OE_N === 1'b0 && OTHER_PORTS_HIZ === 1'b1 &&
               RESET_PORT_OUT === 1'b0 && CPU_RUN === 1'b0)) out_ok = 1'b0;
         low_n++;
         if (low_n == hold) DRV.release_pin();
         step();
      end
      while (CPU_RUN !== 1'b1 && SYS_RESET_N === 1'b1 && settle_n < 3000) begin
         settle_n++;
         step();
      end
      if (low_n == 0 || low_n >= 3000 || settle_n >= 3000) begin
         miscompares++;
         test_done();
      end
   endtask

   task automatic pulse_wd(input logic two);
      @(posedge CORE_CLK);
      if (two) WDOG2_RESET_REQUEST <= 1'b1; else WDOG1_RESET_REQUEST <= 1'b1;
      @(posedge CORE_CLK);
      WDOG1_RESET_REQUEST <= 1'b0; WDOG2_RESET_REQUEST <= 1'b0;
      // step past this edge so a caller sees the reset it launched
      #1;
   endtask

   task automatic filter_after(input int n, input logic exp);
      repeat (n) step();
      check(DIGITAL_FILTER_ON, exp);
   endtask

   initial begin
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      expect_reg(CTRL, 8'h00);
      expect_reg(FLAGS, 8'h00);
      expect_reg(CTRL + 32'h4, 8'h00);
      reg_write(CTRL, 8'h01);
      // a disabled watchdog overflow must not reset anything
      f0 = falls;
      pulse_wd(1'b0);
      repeat (30) step();
      check(falls, f0);
      WDOG1_RESET_ENABLE <= 1'b1;
      WDOG2_RESET_ENABLE <= 1'b1;
      pulse_wd(1'b0);
      measure(0, lo, se);
      check(lo, `RPF_WD1_HOLD_CLKS);
      check(se, 0);
      check(osc_stop_seen, 1'b0);
      check(out_ok, 1'b1);
      expect_reg(FLAGS, 8'h80);
      expect_reg(CTRL, 8'h00);
      // current select is 0, so only the default select may set the wait
      pulse_wd(1'b1);
      measure(0, lo, se);
      check(lo, `RPF_ANALOG_DELAY_NS / `RPF_CLK_PERIOD_NS);
      check(se, SETTLE);
      check(osc_stop_seen & out_ok, 1'b1);
      expect_reg(FLAGS, 8'h90);
      reg_write(FLAGS, 8'h80);
      expect_reg(FLAGS, 8'h80);
      reg_write(CTRL, 8'hff);
      expect_reg(CTRL, 8'h03);
      reg_write(CTRL, 8'h00);
      expect_reg(CTRL, 8'h03);
      filter_after(2, 1'b1);
      MAIN_OSC_RUN <= 1'b0;
      filter_after(6, 1'b0);
      MAIN_OSC_RUN <= 1'b1;
      filter_after(6, 1'b1);
      CLOCK_SOURCE_SELECT <= 1'b1;
      filter_after(4, 1'b0);
      filter_after(20, 1'b0);
      CLOCK_SOURCE_SELECT <= 1'b0;
      filter_after(4, 1'b1);
      STOP_ENTRY <= 1'b1;
      step();
      STOP_ENTRY <= 1'b0;
      filter_after(20, 1'b0);
      STOP_RELEASE <= 1'b1;
      step();
      STOP_RELEASE <= 1'b0;
      filter_after(1, 1'b0);
      // select 0 gives a settle of UNIT cycles; still forced at its last cycle
      filter_after(3, 1'b0);
      filter_after(5, 1'b1);
      // ten samples of 10 cycles: 70 low cycles stay below (N-1)T
      f0 = falls;
      DRV.pulse(70);
      repeat (15) step();
      DRV.pulse(70);
      repeat (60) step();
      check(falls, f0);
      DRV.hold_low();
      measure(60, lo, se);
      check(lo >= 60 && lo <= 65, 1'b1);
      check(se, SETTLE);
      check(osc_stop_seen & out_ok, 1'b1);
      check(DIGITAL_FILTER_ON, 1'b0);
      expect_reg(CTRL, 8'h00);
      expect_reg(FLAGS, 8'h00);
      // twenty samples now: 170 low cycles are still noise
      reg_write(CTRL, 8'h01);
      expect_reg(CTRL, 8'h01);
      f0 = falls;
      DRV.pulse(170);
      repeat (60) step();
      check(falls, f0);
      DRV.pulse(260);
      repeat (60) step();
      check(falls, f0 + 1);
      test_done();
   end

   initial begin
      repeat (20000) @(posedge CORE_CLK);
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire

/* tb/rpf_pin_source.sv */
// Purpose: external reset source that drives the active-low reset pin
// Assumes: the pin has a pull-up, so it idles high between pulses
// Notes:   the pin is asynchronous to the core clock, so changes need not meet an edge
`timescale 1ns/1ps
`default_nettype none
module rpf_pin_source (
   input  wire logic clk,
   output logic      pin_n
);
   initial pin_n = 1'b1;

   task automatic hold_low();
      pin_n <= 1'b0;
   endtask

   task automatic release_pin();
      pin_n <= 1'b1;
   endtask

   // low for n core cycles, then back to the pulled-up level
   task automatic pulse(input int n);
      pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      pin_n <= 1'b1;
   endtask
endmodule
`default_nettype wire
